//--- iwd_pkg.sv
package iwd_pkg;
    // i/o port of the control and status register
    localparam logic [9:0] IWD_PORT_ADDR = 10'h201;
    localparam int IWD_ARM_BIT = 0;
    localparam int IWD_PF_BIT = 1;
    localparam int IWD_DATA_W = 8;
    // clock rate and derived timing
    localparam int IWD_CLK_HZ = 10000000;
    localparam int IWD_CYC_PER_MS = IWD_CLK_HZ / 1000;
    // typical timeout figures in milliseconds
    localparam int IWD_TO_MS_0 = 1600;
    localparam int IWD_TO_MS_1 = 1200;
    localparam int IWD_TO_MS_2 = 600;
    localparam int IWD_TO_MS_3 = 150;
    localparam int IWD_TO_CYC_0 = IWD_TO_MS_0 * IWD_CYC_PER_MS;
    localparam int IWD_TO_CYC_1 = IWD_TO_MS_1 * IWD_CYC_PER_MS;
    localparam int IWD_TO_CYC_2 = IWD_TO_MS_2 * IWD_CYC_PER_MS;
    localparam int IWD_TO_CYC_3 = IWD_TO_MS_3 * IWD_CYC_PER_MS;
    localparam int IWD_CNT_W = 25;
    // reset pulse length in cycles
    localparam int IWD_RST_PULSE_CYC = 16;
    // reset values
    localparam logic IWD_ARM_RST = 1'b0;
    localparam logic IWD_SYNC_RST = 1'b1;
    // service mode selection
    typedef enum logic [1:0] {
        IWD_MODE_OFF = 2'h0,
        IWD_MODE_HW = 2'h1,
        IWD_MODE_SW = 2'h2
    } iwd_mode_e;
    // fail source selection
    typedef enum logic [1:0] {
        IWD_SRC_OFF = 2'h0,
        IWD_SRC_EXT = 2'h1,
        IWD_SRC_BOARD = 2'h2
    } iwd_src_e;
endpackage : iwd_pkg

//--- iwd_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a level
module iwd_sync
    import iwd_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    logic meta_ff;
    logic sync_ff;
    logic nxt_meta;
    logic nxt_sync;

    // first stage feeds only the second
    always_comb begin
        nxt_meta = ce ? din : meta_ff;
        nxt_sync = ce ? meta_ff : sync_ff;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= IWD_SYNC_RST;
            sync_ff <= IWD_SYNC_RST;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign dout = sync_ff;
endmodule : iwd_sync

//--- iwd_pulse.sv
`timescale 1ns/1ps
// fixed-length pulse generator, started by a one-cycle fire
module iwd_pulse
    import iwd_pkg::*;
#(
    parameter int PULSE_CYC = IWD_RST_PULSE_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic fire,
    output logic busy,
    output logic done
);
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic done_ff;
    logic nxt_done;

    // load on fire, count down to zero; done flags the cycle after the last busy one
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_done = 1'b0;
        if (ce) begin
            if (fire && cnt_ff == 8'h00) begin
                nxt_cnt = 8'(PULSE_CYC);
            end else if (cnt_ff != 8'h00) begin
                nxt_cnt = cnt_ff - 8'h01;
                nxt_done = (cnt_ff == 8'h01);
            end
        end else begin
            nxt_done = done_ff;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= 8'h00;
            done_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    assign busy = (cnt_ff != 8'h00);
    assign done = done_ff;
endmodule : iwd_pulse

//--- iwd_top.sv
`timescale 1ns/1ps
// Summary of operation
// - hardware mode: no strobe within timeout gives a system reset pulse.
// - hardware mode is always armed; each address-latch strobe restarts timing.
// - address-enable strobe also services the hardware-mode timer.
// - write with bit 0 set to port 0x201 arms software timer.
// - armed software timer not serviced within period gives reset pulse.
// - any read of port 0x201 restarts the software-mode timeout.
// - write with bit 0 clear to port 0x201 disarms, no reset.
// - after an rstn reset the software timer comes up disarmed; its own reset pulse leaves it armed.
// - low power-fail sense drives channel-check line low.
// - read of port 0x201 returns power status in bit 1.
// - fail source selectable: off, external monitor, or board divider.
module iwd_top
    import iwd_pkg::*;
#(
    parameter int TO_CYC_0 = IWD_TO_CYC_0,
    parameter int TO_CYC_1 = IWD_TO_CYC_1,
    parameter int TO_CYC_2 = IWD_TO_CYC_2,
    parameter int TO_CYC_3 = IWD_TO_CYC_3,
    parameter int PULSE_CYC = IWD_RST_PULSE_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [9:0] io_addr,
    input wire logic io_read_n,
    input wire logic io_write_n,
    input wire logic [iwd_pkg::IWD_DATA_W-1:0] io_wdata,
    input wire logic ale,
    input wire logic aen,
    input wire iwd_pkg::iwd_mode_e mode_sel,
    input wire logic [1:0] timeout_select_jumpers,
    input wire iwd_pkg::iwd_src_e fail_source_jumpers,
    input wire logic external_monitor_input,
    input wire logic supply_good_level,
    output logic [iwd_pkg::IWD_DATA_W-1:0] io_rdata,
    output logic io_rdata_oe,
    output logic sys_reset,
    output logic iochk_n_out,
    output logic iochk_n_oe,
    output logic wd_armed
);
    import iwd_pkg::*;

    logic [IWD_CNT_W-1:0] cnt_ff;
    logic [IWD_CNT_W-1:0] nxt_cnt;
    logic arm_ff;
    logic nxt_arm;
    logic rd_d_ff;
    logic wr_d_ff;
    logic ale_d_ff;
    logic aen_d_ff;
    logic nxt_rd_d;
    logic nxt_wr_d;
    logic nxt_ale_d;
    logic nxt_aen_d;
    logic [IWD_DATA_W-1:0] rdata_ff;
    logic [IWD_DATA_W-1:0] nxt_rdata;
    logic rdoe_ff;
    logic nxt_rdoe;
    logic srst_ff;
    logic nxt_srst;
    logic chk_ff;
    logic nxt_chk;
    logic armed_ff;
    logic nxt_armed;
    logic sel_hit;
    logic rd_strobe;
    logic wr_strobe;
    logic hw_strobe;
    logic raw_good;
    logic good_sync;
    logic timing;
    logic expire;
    logic pulse_busy;
    logic pulse_done;
    logic [IWD_CNT_W-1:0] limit;

    // timeout limit from the strap
    function automatic logic [IWD_CNT_W-1:0] to_limit(input logic [1:0] s);
        case (s)
            2'h0: to_limit = IWD_CNT_W'(TO_CYC_0);
            2'h1: to_limit = IWD_CNT_W'(TO_CYC_1);
            2'h2: to_limit = IWD_CNT_W'(TO_CYC_2);
            default: to_limit = IWD_CNT_W'(TO_CYC_3);
        endcase
    endfunction : to_limit

    // falling edge of an active-low strobe seen against its delayed copy
    function automatic logic fall(input logic now_v, input logic prev_v);
        fall = prev_v & ~now_v;
    endfunction : fall

    // power-fail source mux; disabled source reads as good
    always_comb begin
        unique case (fail_source_jumpers)
            IWD_SRC_EXT: raw_good = external_monitor_input;
            IWD_SRC_BOARD: raw_good = supply_good_level;
            default: raw_good = 1'b1;
        endcase
    end

    // comparator is asynchronous to us, so resync before any use
    iwd_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .din(raw_good),
        .dout(good_sync)
    );

    // io cycles are taken once, on the strobe's leading edge
    assign sel_hit = (io_addr == IWD_PORT_ADDR);
    assign rd_strobe = ce & sel_hit & fall(io_read_n, rd_d_ff);
    assign wr_strobe = ce & sel_hit & fall(io_write_n, wr_d_ff);
    // either bus strobe services hardware mode; rising edge of each
    assign hw_strobe = ce & ((ale & ~ale_d_ff) | (aen & ~aen_d_ff));
    assign limit = to_limit(timeout_select_jumpers);

    // edge history of the bus strobes
    always_comb begin
        nxt_rd_d = ce ? io_read_n : rd_d_ff;
        nxt_wr_d = ce ? io_write_n : wr_d_ff;
        nxt_ale_d = ce ? ale : ale_d_ff;
        nxt_aen_d = ce ? aen : aen_d_ff;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_d_ff <= 1'b1;
            wr_d_ff <= 1'b1;
            ale_d_ff <= 1'b0;
            aen_d_ff <= 1'b0;
        end else begin
            rd_d_ff <= nxt_rd_d;
            wr_d_ff <= nxt_wr_d;
            ale_d_ff <= nxt_ale_d;
            aen_d_ff <= nxt_aen_d;
        end
    end

    // software arm bit; only meaningful in software mode
    always_comb begin
        nxt_arm = arm_ff;
        if (wr_strobe) begin
            nxt_arm = io_wdata[IWD_ARM_BIT];
        end
        // gated by ce as well, so a frozen block keeps its arm bit
        if (ce && mode_sel != IWD_MODE_SW) begin
            nxt_arm = IWD_ARM_RST;
        end
    end

    // reset leaves the arm bit clear, so software starts disarmed
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            arm_ff <= IWD_ARM_RST;
        end else begin
            arm_ff <= nxt_arm;
        end
    end

    // hardware mode needs no enable; default strap never times
    always_comb begin
        unique case (mode_sel)
            IWD_MODE_HW: timing = 1'b1;
            IWD_MODE_SW: timing = arm_ff;
            default: timing = 1'b0;
        endcase
    end

    assign expire = ce & timing & ~pulse_busy & (cnt_ff >= limit - 1'b1);

    // timeout counter; held at zero while idle or pulsing
    always_comb begin
        nxt_cnt = cnt_ff;
        if (ce) begin
            if (!timing || pulse_busy || pulse_done) begin
                nxt_cnt = '0;
            end else if (mode_sel == IWD_MODE_HW && hw_strobe) begin
                nxt_cnt = '0;
            end else if (mode_sel == IWD_MODE_SW && (rd_strobe || wr_strobe)) begin
                nxt_cnt = '0;
            end else if (expire) begin
                nxt_cnt = '0;
            end else begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // a service in the expiry cycle is too late only if it is absent
    iwd_pulse #(
        .PULSE_CYC(PULSE_CYC)
    ) u_pulse (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        // only the strobe of the selected mode may rescue the expiry cycle
        .fire(expire & ~((mode_sel == IWD_MODE_HW) ? hw_strobe
            : (rd_strobe | wr_strobe))),
        .busy(pulse_busy),
        .done(pulse_done)
    );

    // registered outputs: reset pulse, channel check, read data
    always_comb begin
        nxt_srst = srst_ff;
        nxt_chk = chk_ff;
        nxt_rdata = rdata_ff;
        nxt_rdoe = rdoe_ff;
        nxt_armed = armed_ff;
        if (ce) begin
            nxt_srst = pulse_busy;
            nxt_chk = ~good_sync;
            nxt_armed = timing;
            nxt_rdoe = sel_hit & ~io_read_n;
            nxt_rdata = '0;
            nxt_rdata[IWD_PF_BIT] = good_sync;
            nxt_rdata[IWD_ARM_BIT] = arm_ff;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            srst_ff <= 1'b0;
            chk_ff <= 1'b0;
            rdata_ff <= '0;
            rdoe_ff <= 1'b0;
            armed_ff <= 1'b0;
        end else begin
            srst_ff <= nxt_srst;
            chk_ff <= nxt_chk;
            rdata_ff <= nxt_rdata;
            rdoe_ff <= nxt_rdoe;
            armed_ff <= nxt_armed;
        end
    end

    assign sys_reset = srst_ff;
    assign io_rdata = rdata_ff;
    assign io_rdata_oe = rdoe_ff;
    // open-drain channel check: only ever pulled low
    assign iochk_n_out = 1'b0;
    assign iochk_n_oe = chk_ff;
    assign wd_armed = armed_ff;
endmodule : iwd_top

//--- iwd_props.sv
`timescale 1ns/1ps
// port checks of the watchdog and fail monitor
module iwd_props
    import iwd_pkg::*;
#(
    parameter int PULSE_CYC = IWD_RST_PULSE_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [9:0] io_addr,
    input wire logic io_read_n,
    input wire logic io_write_n,
    input wire logic [iwd_pkg::IWD_DATA_W-1:0] io_wdata,
    input wire iwd_pkg::iwd_mode_e mode_sel,
    input wire iwd_pkg::iwd_src_e fail_source_jumpers,
    input wire logic external_monitor_input,
    input wire logic [iwd_pkg::IWD_DATA_W-1:0] io_rdata,
    input wire logic io_rdata_oe,
    input wire logic sys_reset,
    input wire logic iochk_n_oe,
    input wire logic wd_armed
);
    import iwd_pkg::*;
    logic [7:0] hi_ff;
    logic [7:0] nxt_hi;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // cycles the reset pulse has stood so far
    always_comb begin
        nxt_hi = sys_reset ? hi_ff + 8'h01 : 8'h00;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hi_ff <= 8'h00;
        end else begin
            hi_ff <= nxt_hi;
        end
    end
    // write to the port taken in software mode (falling strobe)
    sequence s_wr;
        mode_sel == IWD_MODE_SW && io_addr == IWD_PORT_ADDR && !io_write_n
            && $past(io_write_n);
    endsequence
    property p_len; $fell(sys_reset) |-> hi_ff == PULSE_CYC; endproperty
    a_len: assert property (p_len) else $error("pulse length");
    property p_arm; s_wr ##0 io_wdata[0] |-> ##3 wd_armed; endproperty
    a_arm: assert property (p_arm) else $error("no arm");
    property p_dis; s_wr ##0 !io_wdata[0] |-> ##3 !wd_armed; endproperty
    a_dis: assert property (p_dis) else $error("no disarm");
    property p_quiet;
        (mode_sel == IWD_MODE_SW && !wd_armed)[*3] |-> !$rose(sys_reset);
    endproperty
    a_quiet: assert property (p_quiet) else $error("reset unarmed");
    property p_oe;
        io_rdata_oe |-> $past(io_addr) == IWD_PORT_ADDR && !$past(io_read_n);
    endproperty
    a_oe: assert property (p_oe) else $error("stray read data");
    property p_bit;
        io_rdata_oe && mode_sel == IWD_MODE_SW |-> io_rdata[0] == wd_armed;
    endproperty
    a_bit: assert property (p_bit) else $error("arm bit");
    property p_fail;
        (fail_source_jumpers == IWD_SRC_EXT && !external_monitor_input)[*5]
            |-> iochk_n_oe;
    endproperty
    a_fail: assert property (p_fail) else $error("no check line");
    property p_off; (fail_source_jumpers == IWD_SRC_OFF)[*5] |-> !iochk_n_oe;
    endproperty
    a_off: assert property (p_off) else $error("check line off");
    property p_idle; mode_sel == IWD_MODE_OFF |-> !sys_reset && !wd_armed;
    endproperty
    a_idle: assert property (p_idle) else $error("strap off active");
endmodule : iwd_props

//--- iwd_host.sv
`timescale 1ns/1ps
// host side: isa i/o cycles and bus strobes, driven on falling edges
module iwd_host
    import iwd_pkg::*;
(
    input wire logic clk,
    output logic [9:0] io_addr,
    output logic io_read_n,
    output logic io_write_n,
    output logic [7:0] io_wdata,
    output logic ale,
    output logic aen,
    input wire logic [7:0] io_rdata,
    input wire logic io_rdata_oe,
    input wire logic iochk_n_line
);
    import iwd_pkg::*;
    logic oe_at_rd;
    logic chk_mask = 1'b0; // host image of its channel-check mask bit
    logic nmi_on = 1'b1;
    logic nmi_req;
    // host takes an nmi on channel check only when unmasked and enabled
    assign nmi_req = ~iochk_n_line & ~chk_mask & nmi_on;
    // idle bus from time zero
    initial begin
        io_addr = 10'h000;
        io_read_n = 1'b1;
        io_write_n = 1'b1;
        io_wdata = 8'h00;
        ale = 1'b0;
        aen = 1'b0;
    end
    // one low cycle, then high again so the next strobe edge is seen
    task automatic io_wr(input logic [9:0] a, input logic [7:0] v);
        @(negedge clk);
        io_addr = a;
        io_wdata = v;
        io_write_n = 1'b0;
        @(negedge clk);
        io_write_n = 1'b1;
        io_wdata = ~v; // released data must not look valid
        @(negedge clk);
    endtask : io_wr
    task automatic io_rd(input logic [9:0] a, output logic [7:0] v);
        @(negedge clk);
        io_addr = a;
        io_read_n = 1'b0;
        repeat (2) @(negedge clk);
        v = io_rdata;
        oe_at_rd = io_rdata_oe;
        io_read_n = 1'b1;
        @(negedge clk);
    endtask : io_rd
    task automatic strobe(input logic sel);
        @(negedge clk);
        ale = !sel;
        aen = sel;
        @(negedge clk);
        ale = 1'b0;
        aen = 1'b0;
    endtask : strobe
endmodule : iwd_host

//--- isa_watchdog_power_fail_bench.sv
`timescale 1ns/1ps
module isa_watchdog_power_fail_bench;
    import iwd_pkg::*;
    localparam int TO_C[4] = '{200, 150, 100, 50};
    localparam int PULSE = 16;
    logic clk, rstn, io_read_n, io_write_n, ale, aen, seen;
    logic ext_in, good_in, sys_reset, iochk_n_out, iochk_n_oe, wd_armed;
    logic [9:0] io_addr;
    logic [7:0] io_wdata, io_rdata, d;
    logic [1:0] tsel;
    logic rd_oe, chk_line;
    // open-drain line: the pull-up wins whenever the design lets go
    assign chk_line = iochk_n_oe ? iochk_n_out : 1'b1;
    iwd_mode_e mode_sel;
    iwd_src_e fsrc;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    iwd_top #(.TO_CYC_0(TO_C[0]), .TO_CYC_1(TO_C[1]), .TO_CYC_2(TO_C[2]),
        .TO_CYC_3(TO_C[3]), .PULSE_CYC(PULSE)) iwd_top_inst (
        .clk, .rstn, .ce(1'b1), .io_addr, .io_read_n, .io_write_n, .io_wdata,
        .ale, .aen, .mode_sel, .timeout_select_jumpers(tsel),
        .fail_source_jumpers(fsrc), .external_monitor_input(ext_in),
        .supply_good_level(good_in), .io_rdata, .io_rdata_oe(rd_oe),
        .sys_reset, .iochk_n_out, .iochk_n_oe, .wd_armed);
    iwd_host iwd_host_inst (.clk, .io_addr, .io_read_n, .io_write_n,
        .io_wdata, .ale, .aen, .io_rdata, .io_rdata_oe(rd_oe),
        .iochk_n_line(chk_line));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // a hang is cut off far beyond the expected few thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // returns at the first cycle the reset pulse is seen, or after n
    task automatic watch(input int n, output logic s);
        s = 1'b0;
        for (int c = 0; c < n && !s; c++) begin
            @(negedge clk);
            s = (sys_reset === 1'b1);
        end
    endtask : watch
    task automatic pulse_len();
        int len;
        len = 0;
        while (sys_reset === 1'b1 && len < 64) begin
            len++;
            @(negedge clk);
        end
        check(8'(len), 8'(PULSE));
    endtask : pulse_len
    task automatic do_reset();
        rstn = 1'b0;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        // one edge after release so registered outputs leave reset values
        @(negedge clk);
    endtask : do_reset
    task automatic finish_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        mode_sel = IWD_MODE_OFF;
        tsel = 2'h0;
        fsrc = IWD_SRC_OFF;
        ext_in = 1'b1;
        good_in = 1'b1;
        do_reset();
        watch(300, seen);
        check(8'(seen), 8'h00);
        iwd_host_inst.io_rd(IWD_PORT_ADDR, d);
        check(d, 8'h02);
        check(8'(iwd_host_inst.oe_at_rd), 8'h01);
        iwd_host_inst.io_rd(10'h202, d);
        check(8'(iwd_host_inst.oe_at_rd), 8'h00);
        // hardware mode per period: strobes keep it alive, then starve it
        mode_sel = IWD_MODE_HW;
        for (int i = 0; i < 4; i++) begin
            tsel = 2'(i);
            do_reset();
            check(8'(wd_armed), 8'h01);
            for (int j = 0; j < 4; j++) begin
                iwd_host_inst.strobe(j[0]);
                watch(TO_C[i] - 6, seen);
                check(8'(seen), 8'h00);
            end
            watch(12, seen);
            check(8'(seen), 8'h01);
            pulse_len();
            watch(TO_C[i] - 6, seen);
            check(8'(seen), 8'h00);
            watch(12, seen);
            check(8'(seen), 8'h01);
        end
        // software mode: arm, serve by reads, disarm, then starve
        mode_sel = IWD_MODE_SW;
        tsel = 2'h2;
        do_reset();
        iwd_host_inst.io_rd(IWD_PORT_ADDR, d);
        check(d, 8'h02);
        iwd_host_inst.io_wr(IWD_PORT_ADDR, 8'h01);
        for (int j = 0; j < 4; j++) begin
            watch(TO_C[2] - 20, seen);
            check(8'(seen), 8'h00);
            iwd_host_inst.io_rd(IWD_PORT_ADDR, d);
            check(d, 8'h03);
        end
        iwd_host_inst.io_wr(IWD_PORT_ADDR, 8'h00);
        watch(300, seen);
        check(8'(seen), 8'h00);
        iwd_host_inst.io_wr(IWD_PORT_ADDR, 8'hFF);
        watch(TO_C[2] - 6, seen);
        check(8'(seen), 8'h00);
        watch(12, seen);
        check(8'(seen), 8'h01);
        do_reset();
        iwd_host_inst.io_rd(IWD_PORT_ADDR, d);
        check(d, 8'h02);
        // fail sense: header input, then board divider, low and good
        mode_sel = IWD_MODE_OFF;
        for (int k = 0; k < 4; k++) begin
            fsrc = k[1] ? IWD_SRC_BOARD : IWD_SRC_EXT;
            ext_in = k[0] ^ k[1];
            good_in = ~(k[0] ^ k[1]);
            iwd_host_inst.chk_mask = k[1];
            repeat (6) @(negedge clk);
            check(8'(iochk_n_oe), {7'h00, ~k[0]});
            check(8'(iochk_n_out), 8'h00);
            check(8'(iwd_host_inst.nmi_req), {7'h00, ~k[0] & ~k[1]});
            iwd_host_inst.io_rd(IWD_PORT_ADDR, d);
            check(d, {6'h00, k[0], 1'b0});
        end
        finish_test();
    end
endmodule : isa_watchdog_power_fail_bench
bind iwd_top iwd_props #(.PULSE_CYC(PULSE_CYC)) iwd_props_inst (
    .clk, .rstn, .io_addr, .io_read_n, .io_write_n, .io_wdata, .mode_sel,
    .fail_source_jumpers, .external_monitor_input, .io_rdata, .io_rdata_oe,
    .sys_reset, .iochk_n_oe, .wd_armed);
